/* File: hdl/zxd_pkg.sv */
package zxd_pkg;

    // apb geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h21f;
    localparam logic [ADDR_W-1:0] STAT_IDX = 12'h220;
    localparam logic [ADDR_W-1:0] MASK_IDX = 12'h221;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX[ADDR_W-3:0], 2'b00};

    // control register field positions
    localparam int SOFT_EN_BIT = 7;
    localparam int STATE_BIT = 5;
    localparam int INVERT_BIT = 4;
    localparam int RISE_EN_BIT = 1;
    localparam int FALL_EN_BIT = 0;

    // status and mask layout
    localparam int FLAG_BIT = 0;

    // reset values
    localparam logic CTRL_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic MASK_RST = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // software-written control fields
    typedef struct packed {
        logic soft_enable;
        logic invert_select;
        logic rise_irq_enable;
        logic fall_irq_enable;
    } zxd_ctrl_t;

    // edge detector results
    typedef struct packed {
        logic sync_level;
        logic crossing_state;
        logic rise;
        logic fall;
    } zxd_edge_t;

endpackage

/* File: hdl/zxd_edge.sv */
`timescale 1ns/10ps
module zxd_edge
    import zxd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw_sink,
    input wire logic invert_select,
    output zxd_edge_t ev
);

    logic meta_q;
    logic sync_q;
    logic out_q;
    logic prev_q;

    // two-flop synchroniser; meta_q feeds sync_q only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_sink;
            sync_q <= meta_q;
        end
    end

    // polarity applied before the edge detectors, so inversion moves edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            out_q <= sync_q ^ invert_select;
            prev_q <= out_q;
        end
    end

    // separate rise and fall detectors on the logic output
    assign ev.sync_level = sync_q;
    assign ev.crossing_state = out_q;
    assign ev.rise = out_q & ~prev_q;
    assign ev.fall = ~out_q & prev_q;

endmodule

/* File: hdl/zxd_top.sv */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
// Summary of operation
// - front end sinks above the reference, sources below; input is that direction
// - uninverted, crossing state is 1 while sinking, 0 while sourcing
// - invert select flips the crossing state meaning
// - edge detection looks at the output after inversion
// - crossing state is exported for other peripherals
// - separate rise and fall detectors; events only on output change
// - flag sets on enabled rising or enabled falling edge
// - writing a new invert value makes an edge even when disabled
// - an edge in the clearing cycle keeps the flag set
// - fuse-enabled detector ignores soft enable; else soft enable controls it
// - control register at its index with the documented bit positions
module zxd_top
    import zxd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sink_active,
    input wire logic fuse_soft_ctrl,
    output logic detector_active,
    output logic crossing_state,
    output logic irq
);

    zxd_ctrl_t ctrl_q;
    zxd_edge_t ev;
    logic flag_q;
    logic flag_d;
    logic mask_q;
    logic irq_q;
    logic active_q;
    logic pready_q;
    logic pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic setup;
    logic wr_en;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic lane0;
    logic edge_set;
    logic flag_clr;
    logic raw_gated;

    // address decode
    assign hit_ctrl = (paddr == CTRL_ADDR);
    assign hit_stat = (paddr == STAT_ADDR);
    assign hit_mask = (paddr == MASK_ADDR);
    assign lane0 = pstrb[0];

    // setup cycle prepares the answer; access completes one cycle later
    assign setup = psel & ~penable & ~pready_q;
    assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

    // apb handshake: no wait states, answer registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pready_q <= 1'b1;
            pslverr_q <= ~(hit_ctrl | hit_stat | hit_mask);
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // read data; unmapped or write cycles return zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_RST;
        end else if (setup && !pwrite) begin
            prdata_q <= RDATA_RST;
            if (hit_ctrl) begin
                prdata_q[SOFT_EN_BIT] <= ctrl_q.soft_enable;
                prdata_q[STATE_BIT] <= ev.crossing_state;
                prdata_q[INVERT_BIT] <= ctrl_q.invert_select;
                prdata_q[RISE_EN_BIT] <= ctrl_q.rise_irq_enable;
                prdata_q[FALL_EN_BIT] <= ctrl_q.fall_irq_enable;
            end else if (hit_stat) begin
                prdata_q[FLAG_BIT] <= flag_q;
            end else if (hit_mask) begin
                prdata_q[FLAG_BIT] <= mask_q;
            end
        end else if (!setup) begin
            prdata_q <= RDATA_RST; // zero outside an answer keeps it tidy
        end
    end

    // control register; the state bit is read-only and ignored on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '{CTRL_RST, CTRL_RST, CTRL_RST, CTRL_RST};
        end else if (wr_en && hit_ctrl && lane0) begin
            ctrl_q.soft_enable <= pwdata[SOFT_EN_BIT];
            ctrl_q.invert_select <= pwdata[INVERT_BIT];
            ctrl_q.rise_irq_enable <= pwdata[RISE_EN_BIT];
            ctrl_q.fall_irq_enable <= pwdata[FALL_EN_BIT];
        end
    end

    // mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RST;
        end else if (wr_en && hit_mask && lane0) begin
            mask_q <= pwdata[FLAG_BIT];
        end
    end

    // fuse left clear keeps the detector on whatever soft enable says
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
        end else begin
            active_q <= ~fuse_soft_ctrl | ctrl_q.soft_enable;
        end
    end

    // a disabled detector reads as source active, so only an invert
    // change can move the logic output then
    assign raw_gated = sink_active & active_q;

    zxd_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .raw_sink(raw_gated),
        .invert_select(ctrl_q.invert_select),
        .ev(ev)
    );

    // enabled edges set the flag; invert writes reach here as edges too
    assign edge_set = (ev.rise & ctrl_q.rise_irq_enable) |
                      (ev.fall & ctrl_q.fall_irq_enable);
    assign flag_clr = wr_en & hit_stat & lane0 & pwdata[FLAG_BIT];

    // set wins over a write-one-to-clear in the same cycle
    always_comb begin
        flag_d = flag_q;
        if (flag_clr) begin
            flag_d = 1'b0;
        end
        if (edge_set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // level interrupt while an unmasked status bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q & mask_q;
        end
    end

    // outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign detector_active = active_q;
    assign crossing_state = ev.crossing_state;
    assign irq = irq_q;

    // checks run on the single clock with reset as disable
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    flag_set_a: assert property (edge_set |=> flag_q)
        else $error("enabled edge did not set the flag");

    set_wins_a: assert property (edge_set && flag_clr |=> flag_q)
        else $error("clear beat a simultaneous edge");

    flag_sticky_a: assert property (
        flag_q && !flag_clr |=> flag_q)
        else $error("flag dropped without a software clear");

    flag_cause_a: assert property (
        !flag_q ##1 flag_q |-> $past(edge_set))
        else $error("flag rose with no enabled edge");

    state_pol_a: assert property (
        ##1 ev.crossing_state ==
        ($past(ev.sync_level) ^ $past(ctrl_q.invert_select)))
        else $error("crossing state not sync level xor invert");

    rise_edge_a: assert property (
        ev.rise |-> ev.crossing_state && !$past(ev.crossing_state))
        else $error("rise pulse without a low to high change");

    invert_edge_a: assert property (
        $changed(ctrl_q.invert_select) && $stable(ev.sync_level)
        |=> ev.rise || ev.fall)
        else $error("invert change made no edge");

    sync_delay_a: assert property (
        $rose(raw_gated) ##1 raw_gated |=> ev.sync_level)
        else $error("raw level not through two flops");

    fuse_active_a: assert property (
        ##1 active_q == ($past(~fuse_soft_ctrl) ||
        $past(ctrl_q.soft_enable)))
        else $error("detector enable ignores fuse or soft enable");

    irq_level_a: assert property (
        flag_q && mask_q |=> irq_q)
        else $error("unmasked flag gave no interrupt");

    apb_answer_a: assert property (setup |=> pready_q ##1 !pready_q)
        else $error("apb answer not one cycle after setup");

    rise_flag_c: cover property (ev.rise && ctrl_q.rise_irq_enable);
    fall_flag_c: cover property (ev.fall && ctrl_q.fall_irq_enable);
    set_clear_c: cover property (edge_set && flag_clr);
    invert_off_c: cover property (
        $changed(ctrl_q.invert_select) && !active_q);
    irq_seen_c: cover property ($rose(irq_q));

endmodule

/* File: tb/zxd_ac_source.sv */
`timescale 1ns/10ps
// far-side signal: square wave while run, else a held level
module zxd_ac_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic level,
    input wire logic [7:0] half,
    output logic sink_active
);
    logic [7:0] cnt_q;
    logic osc_q;
    // half period is half+1 clocks; a large half models a slow mains wave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            osc_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h00;
            osc_q <= level;
        end else if (cnt_q >= half) begin
            cnt_q <= 8'h00;
            osc_q <= ~osc_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // 1 = pin above the reference, front end sinking
    assign sink_active = run ? osc_q : level;
endmodule

/* File: tb/zero_cross_detect_logic_test.sv */
`timescale 1ns/10ps
module zero_cross_detect_logic_test
    import zxd_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic fuse = 1, run = 0, lvl = 0, rerr, inv, nw;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat, seed = 32'h5366530d;
    logic [7:0] half = 8'h03;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] en;
    logic [31:0] prdata;
    logic pready, pslverr, sink, det, cst, irq;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    always #5 pclk = ~pclk;
    zxd_ac_source i_src (.pclk(pclk), .presetn(presetn), .run(run),
        .level(lvl), .half(half), .sink_active(sink));
    zxd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sink_active(sink), .fuse_soft_ctrl(fuse),
        .detector_active(det), .crossing_state(cst), .irq(irq));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            bad_count++;
            $display("BAD %s exp %h saw %h", n, x, s);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run;
        end
    end
    initial begin
        w(2);
        presetn <= 1;
        w(1);
        apb(0, CTRL_ADDR, 0); chk("ctrl rst", rdat, 0);
        apb(0, STAT_ADDR, 0); chk("flag rst", rdat, 0);
        apb(0, 12'h000, 0); chk("unmapped", {31'h0, rerr}, 1);
        chk("det off", {31'h0, det}, 0);
        // invert change with the detector off still flags
        apb(1, CTRL_ADDR, 32'h12);
        w(20);
        apb(0, STAT_ADDR, 0); chk("inv flag", rdat, 1);
        apb(1, MASK_ADDR, 1);
        w(3);
        chk("irq on", {31'h0, irq}, 1);
        apb(1, STAT_ADDR, 1);
        w(3);
        apb(0, STAT_ADDR, 0); chk("flag clr", rdat, 0);
        chk("irq off", {31'h0, irq}, 0);
        // a write with lane 0 strobe low must leave control as it was
        pstrb <= 4'h0;
        apb(1, CTRL_ADDR, 32'h80);
        pstrb <= 4'hf;
        apb(0, CTRL_ADDR, 0); chk("strb off", rdat, 32'h32);
        // random level and polarity, soft enable on
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            inv = seed[0];
            lvl <= seed[1];
            apb(1, CTRL_ADDR, {27'h4, inv, 4'h0});
            w(5);
            chk("det on", {31'h0, det}, 1);
            chk("state", {31'h0, cst}, {31'h0, seed[1] ^ inv});
            apb(0, CTRL_ADDR, 0);
            chk("ctrl rd", rdat,
                {24'h0, 2'b10, seed[1] ^ inv, inv, 4'h0});
        end
        // every polarity and enable pair against one input edge
        for (int i = 0; i < 8; i++) begin
            inv = i[2];
            en = i[1:0];
            apb(1, CTRL_ADDR, {27'h4, inv, 2'b00, en});
            w(6);
            apb(1, STAT_ADDR, 1);
            nw = ~lvl;
            lvl <= nw;
            w(6);
            apb(0, STAT_ADDR, 0);
            chk("edge", rdat, {31'h0, (nw ^ inv) ? en[1] : en[0]});
        end
        // edge lands on the clearing write; the set wins
        apb(1, CTRL_ADDR, 32'h83);
        lvl <= ~lvl;
        w(6);
        lvl <= ~lvl;
        @(posedge pclk);
        apb(1, STAT_ADDR, 1);
        w(2);
        apb(0, STAT_ADDR, 0); chk("set wins", rdat, 1);
        // fuse keeps it on with soft enable clear; running wave
        fuse <= 0;
        apb(1, CTRL_ADDR, 32'h03);
        w(2);
        chk("fuse on", {31'h0, det}, 1);
        apb(1, STAT_ADDR, 1);
        seed = xs(seed);
        half <= {4'h0, seed[3:0]};
        run <= 1;
        w(200);
        run <= 0;
        apb(0, STAT_ADDR, 0); chk("wave flag", rdat, 1);
        chk("wave irq", {31'h0, irq}, 1);
        complete_run;
    end
endmodule
